/* design/bss_map.svh */
// Register map, field positions, timing and fault codes of the burner sequencer
`ifndef BSS_MAP_SVH
`define BSS_MAP_SVH

// =============================================================
// Register byte offsets
`define BSS_CTRL_OFS     12'h000
`define BSS_STAT_OFS     12'h004
`define BSS_OPS_OFS      12'h008

// =============================================================
// Field positions
`define BSS_CTRL_RST_BIT 0
`define BSS_STAT_LOCK_BIT 4
`define BSS_STAT_HOLD_BIT 5
`define BSS_STAT_OUT_LSB 8
`define BSS_STAT_FLT_LSB 16

// =============================================================
// Timebase: one tick per second
`define BSS_CLK_NS       20
`define BSS_SEC_NS       1000000000
`define BSS_SETTLE_CYC   3'h4

// =============================================================
// Sequence times in seconds; the hold and strap limits also given in minutes and hours
`define BSS_INIT_S       10'h00A
`define BSS_HOLD_SHOW_S  10'h005
`define BSS_HOLD_MAX_MIN 4
`define BSS_HOLD_MAX_S   10'(`BSS_HOLD_MAX_MIN * 60)
`define BSS_SBY_FLAME_S  10'h0F0
`define BSS_SBY_PI_S     10'h01E
`define BSS_TRIAL_LONG_S 10'h00A
`define BSS_TRIAL_SHRT_S 10'h004
`define BSS_MFEP_S       10'h00A
`define BSS_PI_CLOSE_S   10'h005
`define BSS_STRAP_HOURS  200
`define BSS_STRAP_S      20'(`BSS_STRAP_HOURS * 3600)

// =============================================================
// Fault codes
`define BSS_FLT_NONE     8'h00
`define BSS_FLT_HOLD     8'h01
`define BSS_FLT_FLAME    8'h02
`define BSS_FLT_SENSE    8'h03
`define BSS_FLT_PI       8'h04
`define BSS_FLT_IFAULT   8'h05
`define BSS_FLT_NOFLAME  8'h06
`define BSS_FLT_LOSS     8'h07
`define BSS_FLT_AMP      8'h2E
`define BSS_FLT_STRAP    8'h6E

`endif

/* design/bss_pkg.sv */
// Types shared by the burner sequencer modules
package bss_pkg;

  // =============================================================
  // Sequence states
  typedef enum logic [2:0] {
    ST_INIT, ST_SBY, ST_SSC, ST_PTRIAL, ST_MFEP, ST_RUN, ST_LOCK
  } bss_state_e;

  typedef logic [9:0]  bss_sec_t;
  typedef logic [7:0]  bss_fault_t;
  typedef logic [3:0]  bss_out_t;

endpackage : bss_pkg

/* design/bss_seq.sv */
// Flame safeguard sequencer top with APB register slave
// Notes on behaviour
// (R1) Power-up: initiate ten seconds with good supply
// (R2) Supply out of tolerance returns to initiate
// (R3) Bad supply in initiate: hold, shown five seconds
// (R4) Hold lasting four minutes locks out
// (R5) Strap change after 200 hours: hard lockout
// (R6) Standby flame for 240 seconds locks out
// (R7) Energized outputs or open interlock lock out
// (R8) Standby interlock open 30 seconds locks out
// (R9) Slow amplifier with relight strap: fault 46
// (R10) Leave standby on demand, limit, circuits good
// (R11) Flame at safe start check returns standby
// (R12) Pilot trial: pilot, ignition; flame by end
// (R13) Pilot trial output sense mismatch locks out
// (R14) Intermittent: flame proven, ignition off, mains on
// (R15) Interrupted: mains at trial end, pilot later
// (R16) Pilot-mode strap intact selects intermittent pilot
// (R17) Run lasts until demand input opens
// (R18) Run output sense mismatch locks out
// (R19) Run flame loss: lockout or relight by strap
// (R20) Interlock must close five seconds after shutdown
// (R21) Internal fault in active states locks out
// (R22) Lockout reset accepted only while powered
// (R23) Lockout drops all outputs, latched until reset
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`include "bss_map.svh"
module bss_seq #(
  parameter int unsigned TICK_CYC = `BSS_SEC_NS / `BSS_CLK_NS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Supply and controls
  input  wire logic        line_ok,
  input  wire logic        demand,
  input  wire logic        limit_ok,
  input  wire logic        flame,
  input  wire logic        preignition_interlock,
  input  wire logic        amp_slow_fitted,
  input  wire logic        internal_fault,
  input  wire logic        reset_button,
  // Straps, high when intact
  input  wire logic        trial_length_strap,
  input  wire logic        flame_loss_action_strap,
  input  wire logic        pilot_mode_strap,
  // Output terminal sense
  input  wire logic        ign_sense,
  input  wire logic        pilot_sense,
  input  wire logic        upstream_main_valve_sense,
  input  wire logic        downstream_main_valve_sense,
  // Load outputs and indication
  output logic             ign_out,
  output logic             pilot_out,
  output logic             upstream_main_valve,
  output logic             downstream_main_valve,
  output logic             lockout,
  output logic             hold_ind
);
  import bss_pkg::*;

  // =============================================================
  // Declarations
  bss_tim_if  tif ();
  bss_state_e state_q, state_d;
  bss_fault_t fault_q, code_d;
  bss_sec_t   sec_q, hold_s_q, show_s_q, flame_s_q, pi_s_q, trial_s;
  bss_out_t   cmd_q, cmd_d, sense;
  logic [2:0] settle_q;
  logic       hard_q, post_q, hold_q, lock_q, soft_rst_q;
  logic       pready_q, pslverr_q;
  logic [31:0] prdata_q, stat;
  logic       act, settled, mismatch, relight, intermit;

  // =============================================================
  // Timebase and strap monitor
  bss_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .clk    (clk),
    .resetn (resetn),
    .tif    (tif)
  );

  bss_strap_mon u_mon (
    .clk    (clk),
    .resetn (resetn),
    .straps ({trial_length_strap, flame_loss_action_strap, pilot_mode_strap}),
    .tif    (tif)
  );

  // =============================================================
  // Strap decode and output sense
  assign relight  = flame_loss_action_strap;
  assign intermit = pilot_mode_strap;                                    // [R16]
  assign trial_s  = trial_length_strap ? `BSS_TRIAL_LONG_S : `BSS_TRIAL_SHRT_S;
  assign sense    = {ign_sense, pilot_sense, upstream_main_valve_sense,
                     downstream_main_valve_sense};
  assign act      = state_q inside {ST_SBY, ST_SSC, ST_PTRIAL, ST_MFEP, ST_RUN};
  assign settled  = (settle_q == `BSS_SETTLE_CYC);
  // Sensed terminals must follow the commanded loads once settled
  assign mismatch = settled && (sense != cmd_q);

  // =============================================================
  // Next state and lockout cause
  always_comb begin
    state_d = state_q;
    code_d  = `BSS_FLT_NONE;
    case (state_q)
      ST_INIT: begin
        if (!line_ok) begin
          if (hold_s_q >= `BSS_HOLD_MAX_S) begin
            code_d = `BSS_FLT_HOLD;                                     // [R4]
          end
        end else if (sec_q >= `BSS_INIT_S) begin
          state_d = ST_SBY;                                             // [R1]
        end
      end
      ST_SBY: begin
        if (flame && flame_s_q >= `BSS_SBY_FLAME_S) begin
          code_d = `BSS_FLT_FLAME;                                      // [R6]
        end else if (!preignition_interlock && pi_s_q >= `BSS_SBY_PI_S) begin
          code_d = `BSS_FLT_PI;                                         // [R8]
        end else if (!preignition_interlock && post_q && sec_q >= `BSS_PI_CLOSE_S) begin
          code_d = `BSS_FLT_PI;                                         // [R20]
        end else if (demand && limit_ok && settled && preignition_interlock) begin
          state_d = ST_SSC;                                             // [R10]
        end
      end
      ST_SSC: begin
        if (!preignition_interlock) begin
          code_d = `BSS_FLT_PI;                                         // [R7]
        end else if (flame) begin
          state_d = ST_SBY;                                             // [R11]
        end else begin
          // Valve proving is not fitted, so the trial follows directly
          state_d = ST_PTRIAL;                                          // [R11]
        end
      end
      ST_PTRIAL: begin
        if (flame && intermit) begin
          state_d = ST_RUN;                                             // [R14]
        end else if (sec_q >= trial_s) begin
          if (!flame) begin
            code_d = `BSS_FLT_NOFLAME;                                  // [R12]
          end else begin
            state_d = ST_MFEP;                                          // [R15]
          end
        end
      end
      ST_MFEP: begin
        if (!flame) begin
          code_d = `BSS_FLT_LOSS;
        end else if (sec_q >= `BSS_MFEP_S) begin
          state_d = ST_RUN;                                             // [R15]
        end
      end
      ST_RUN: begin
        if (!demand) begin
          state_d = ST_SBY;                                             // [R17]
        end else if (!flame) begin
          if (relight) begin
            state_d = ST_PTRIAL;                                        // [R19]
          end else begin
            code_d = `BSS_FLT_LOSS;                                     // [R19]
          end
        end
      end
      ST_LOCK: begin
        // Reset only with supply present; a strap lock never clears
        if ((reset_button || soft_rst_q) && line_ok && !hard_q) begin
          state_d = ST_INIT;                                            // [R22]
        end
      end
      default: state_d = ST_LOCK;
    endcase
    // Faults common to all active states, highest priority last
    if (act && mismatch) begin
      code_d = `BSS_FLT_SENSE;                                          // [R7] [R13] [R18]
    end
    if (act && amp_slow_fitted && relight) begin
      code_d = `BSS_FLT_AMP;                                            // [R9]
    end
    if (act && internal_fault) begin
      code_d = `BSS_FLT_IFAULT;                                         // [R21]
    end
    if (act && !line_ok) begin
      state_d = ST_INIT;                                                // [R2]
      code_d  = `BSS_FLT_NONE;
    end
    if (state_q != ST_LOCK && tif.strap_err) begin
      code_d = `BSS_FLT_STRAP;                                          // [R5]
    end
    if (code_d != `BSS_FLT_NONE) begin
      state_d = ST_LOCK;                                                // [R23]
    end
  end

  // =============================================================
  // Commanded loads {ignition, pilot, upstream, downstream}
  always_comb begin
    case (state_d)
      ST_PTRIAL: cmd_d = 4'hC;                                          // [R12]
      ST_MFEP:   cmd_d = 4'h7;                                          // [R15]
      ST_RUN:    cmd_d = {1'b0, intermit, 2'b11};                       // [R14] [R18]
      default:   cmd_d = 4'h0;                                          // [R23]
    endcase
  end

  // State, loads and lockout indication
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= ST_INIT;
      cmd_q   <= 4'h0;
      lock_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q   <= cmd_d;
      lock_q  <= (state_d == ST_LOCK);                                  // [R23]
    end
  end

  // Fault code kept while locked; strap lock is hard
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fault_q <= 8'h00;
      hard_q  <= 1'b0;
    end else if (state_q != ST_LOCK && state_d == ST_LOCK) begin
      fault_q <= code_d;
      hard_q  <= (code_d == `BSS_FLT_STRAP);                            // [R5]
    end else if (state_d == ST_INIT && state_q == ST_LOCK) begin
      fault_q <= 8'h00;
    end
  end

  // =============================================================
  // Terminal sense settling after any load change
  always_ff @(posedge clk) begin
    if (!resetn || cmd_d != cmd_q) begin
      settle_q <= 3'h0;
    end else if (!settled) begin
      settle_q <= settle_q + 3'h1;
    end
  end

  // Seconds in the current state; bad supply restarts initiate
  always_ff @(posedge clk) begin
    if (!resetn || state_d != state_q || (state_q == ST_INIT && !line_ok)) begin
      sec_q <= 10'h000;                                                 // [R3]
    end else if (tif.tick && sec_q != 10'h3FF) begin
      sec_q <= sec_q + 10'h001;
    end
  end

  // Length of the initiate hold
  always_ff @(posedge clk) begin
    if (!resetn || state_q != ST_INIT || line_ok) begin
      hold_s_q <= 10'h000;
    end else if (tif.tick && hold_s_q != 10'h3FF) begin
      hold_s_q <= hold_s_q + 10'h001;                                   // [R4]
    end
  end

  // Hold indication stays up at least its minimum show time unless lockout is entered first
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hold_q   <= 1'b0;
      show_s_q <= 10'h000;
    end else if (state_d == ST_INIT && !line_ok) begin
      hold_q   <= 1'b1;                                                 // [R3]
      show_s_q <= 10'h000;
    end else if (state_d == ST_LOCK || (line_ok && show_s_q >= `BSS_HOLD_SHOW_S)) begin
      hold_q   <= 1'b0;
    end else if (hold_q && tif.tick && show_s_q != 10'h3FF) begin
      show_s_q <= show_s_q + 10'h001;
    end
  end

  // Standby flame and open interlock durations
  always_ff @(posedge clk) begin
    if (!resetn || state_q != ST_SBY) begin
      flame_s_q <= 10'h000;
      pi_s_q    <= 10'h000;
    end else if (tif.tick) begin
      flame_s_q <= (flame && flame_s_q != 10'h3FF) ? flame_s_q + 10'h001 : 10'h000;
      pi_s_q    <= (!preignition_interlock && pi_s_q != 10'h3FF) ? pi_s_q + 10'h001 : 10'h000;
    end
  end

  // Armed when the valves drop at end of demand
  always_ff @(posedge clk) begin
    if (!resetn) begin
      post_q <= 1'b0;
    end else if (state_d == ST_SBY && state_q inside {ST_RUN, ST_MFEP}) begin
      post_q <= 1'b1;                                                   // [R20]
    end else if (state_q != ST_SBY || preignition_interlock) begin
      post_q <= 1'b0;
    end
  end

  // =============================================================
  // APB slave: one wait state, answer registered
  always_comb begin
    stat = 32'h00000000;
    stat[2:0] = state_q;
    stat[`BSS_STAT_LOCK_BIT] = lock_q;
    stat[`BSS_STAT_HOLD_BIT] = hold_q;
    stat[`BSS_STAT_OUT_LSB +: 4] = cmd_q;
    stat[`BSS_STAT_FLT_LSB +: 8] = fault_q;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
      if (psel && penable && !pready_q) begin
        if (paddr == `BSS_CTRL_OFS) begin
          prdata_q <= 32'h00000000;
        end else if (paddr == `BSS_STAT_OFS) begin
          prdata_q <= pwrite ? 32'h00000000 : stat;
        end else if (paddr == `BSS_OPS_OFS) begin
          prdata_q <= pwrite ? 32'h00000000 : {12'h000, tif.op_secs};
        end else begin
          pslverr_q <= 1'b1;
        end
      end
    end
  end

  // Software lockout reset, a one-cycle pulse
  always_ff @(posedge clk) begin
    if (!resetn) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= psel && penable && pready_q && pwrite && paddr == `BSS_CTRL_OFS
                    && pwdata[`BSS_CTRL_RST_BIT];
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign ign_out               = cmd_q[3];
  assign pilot_out             = cmd_q[2];
  assign upstream_main_valve   = cmd_q[1];
  assign downstream_main_valve = cmd_q[0];
  assign lockout               = lock_q;
  assign hold_ind              = hold_q;

  // =============================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_mfep_end;
    state_q == ST_MFEP && flame && line_ok && sec_q >= `BSS_MFEP_S && code_d == 8'h00;
  endsequence
  sequence s_pilot_dropped;
    state_q == ST_RUN && !cmd_q[2] && cmd_q[1:0] == 2'b11;
  endsequence

  property p_lock_loads;
    lock_q |-> cmd_q == 4'h0 && state_q == ST_LOCK;
  endproperty
  a_lock_loads: assert property (p_lock_loads) else $error("loads on in lockout"); // [R23]

  property p_lock_latch;
    lock_q && !(reset_button || soft_rst_q) |=> lock_q;
  endproperty
  a_lock_latch: assert property (p_lock_latch) else $error("lockout left unreset"); // [R23]

  property p_reset_powered;
    lock_q && !line_ok |=> lock_q;
  endproperty
  a_reset_powered: assert property (p_reset_powered) else $error("reset without supply"); // [R22]

  property p_line_init;
    act && !line_ok && !tif.strap_err |=> state_q == ST_INIT && cmd_q == 4'h0;
  endproperty
  a_line_init: assert property (p_line_init) else $error("supply loss ignored"); // [R2]

  property p_init_done;
    state_q == ST_INIT && line_ok && sec_q >= `BSS_INIT_S && !tif.strap_err
      |=> state_q == ST_SBY;
  endproperty
  a_init_done: assert property (p_init_done) else $error("initiate did not end"); // [R1]

  property p_trial_loads;
    state_q == ST_PTRIAL |-> cmd_q == 4'hC;
  endproperty
  a_trial_loads: assert property (p_trial_loads) else $error("trial loads wrong"); // [R12]

  property p_no_flame;
    state_q == ST_PTRIAL && line_ok && !flame && sec_q >= trial_s |=> lock_q;
  endproperty
  a_no_flame: assert property (p_no_flame) else $error("trial ended unlit"); // [R12]

  property p_intermittent;
    state_q == ST_PTRIAL && flame && intermit && line_ok && code_d == 8'h00
      |=> cmd_q == 4'h7;
  endproperty
  a_intermittent: assert property (p_intermittent) else $error("mains not opened"); // [R14]

  property p_interrupted;
    s_mfep_end |=> s_pilot_dropped;
  endproperty
  a_interrupted: assert property (p_interrupted) else $error("pilot not dropped"); // [R15]

  property p_relight;
    state_q == ST_RUN && demand && !flame && relight && line_ok && code_d == 8'h00
      |=> state_q == ST_PTRIAL;
  endproperty
  a_relight: assert property (p_relight) else $error("relight not tried"); // [R19]

  property p_guard;
    act && line_ok && (internal_fault || mismatch || (amp_slow_fitted && relight))
      |=> lock_q ##1 lock_q || state_q == ST_INIT;
  endproperty
  a_guard: assert property (p_guard) else $error("fault did not lock out"); // [R21]

endmodule : bss_seq

/* design/bss_strap_mon.sv */
// Strap capture and operating-time meter
`timescale 1ns/1ns
`include "bss_map.svh"
module bss_strap_mon (
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Straps
  input wire logic [2:0] straps,
  // Timebase and report
  bss_tim_if.mon         tif
);

  logic [2:0] ref_q;
  logic       cap_q;

  // =============================================================
  // Operating seconds, saturating so the lock stays armed
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tif.op_secs <= 20'h00000;
    end else if (tif.tick && tif.op_secs != 20'hFFFFF) begin
      tif.op_secs <= tif.op_secs + 20'h00001;
    end
  end

  // Capture after release; early changes are simply accepted
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cap_q         <= 1'b0;
      ref_q         <= 3'h0;
      tif.strap_err <= 1'b0;
    end else if (!cap_q) begin
      cap_q <= 1'b1;
      ref_q <= straps;
    end else if (straps != ref_q) begin
      if (tif.op_secs >= `BSS_STRAP_S) begin
        tif.strap_err <= 1'b1; // [R5]
      end else begin
        ref_q <= straps;
      end
    end
  end

  property p_strap_lock;
    @(posedge clk) disable iff (!resetn)
      cap_q && straps != ref_q && tif.op_secs >= `BSS_STRAP_S |=> tif.strap_err;
  endproperty
  a_strap_lock: assert property (p_strap_lock) else $error("late strap change missed"); // [R5]

endmodule : bss_strap_mon

/* design/bss_tick.sv */
// One-second tick generator
`timescale 1ns/1ns
module bss_tick #(
  parameter int unsigned TICK_CYC = 50000000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Timebase
  bss_tim_if.gen   tif
);

  logic [25:0] cnt_q;

  // =============================================================
  // Free-running divider, tick on the last count
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q    <= 26'h0000000;
      tif.tick <= 1'b0;
    end else begin
      tif.tick <= (cnt_q == 26'(TICK_CYC - 1));
      cnt_q    <= (cnt_q == 26'(TICK_CYC - 1)) ? 26'h0000000 : cnt_q + 26'h0000001;
    end
  end

  property p_tick_pulse;
    @(posedge clk) disable iff (!resetn) tif.tick |=> !tif.tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");

endmodule : bss_tick

/* design/bss_tim_if.sv */
// Timebase and strap monitor signals between sequencer modules
`timescale 1ns/1ns
interface bss_tim_if;
  logic        tick;
  logic        strap_err;
  logic [19:0] op_secs;

  modport gen (output tick);
  modport mon (input tick, output strap_err, output op_secs);
  modport seq (input tick, input strap_err, input op_secs);
endinterface : bss_tim_if

/* sim/bss_plant.sv */
// Far-side model: load terminals and their sense feedback
`timescale 1ns/1ns
module bss_plant (
  // Clock
  input  wire logic       clk,
  // Loads from the sequencer {ign, pilot, up, down}
  input  wire logic [3:0] loads,
  // Terminal sense back to the sequencer
  output logic      [3:0] sense
);
  // =============================================================
  // Terminals
  // Sense trails the loads by one edge, inside the settle allowance
  initial sense = 4'h0;
  always @(posedge clk) begin
    sense <= loads;
  end
endmodule : bss_plant

/* sim/burner_safety_sequencer_test.sv */
// Self-checking bench for the burner sequencer
`timescale 1ns/1ns
`include "bss_map.svh"
module burner_safety_sequencer_test;
  // =============================================================
  // Stimulus and observation
  logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, lockout, hold_ind;
  logic        line_ok = 1'b1, demand = 1'b0, limit_ok = 1'b0, flame = 1'b0;
  logic        pil = 1'b0, amp = 1'b0, ifault = 1'b0, rbtn = 1'b0;
  logic [2:0]  straps = 3'h7;
  logic [3:0]  loads, sense;
  int          failures = 0, tests_run = 0, cyc = 0;

  always #10 clk = ~clk;

  bss_seq #(.TICK_CYC(10)) i_bss_seq (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_ok(line_ok), .demand(demand), .limit_ok(limit_ok), .flame(flame),
    .preignition_interlock(pil), .amp_slow_fitted(amp), .internal_fault(ifault),
    .reset_button(rbtn), .trial_length_strap(straps[2]),
    .flame_loss_action_strap(straps[1]), .pilot_mode_strap(straps[0]),
    .ign_sense(sense[3]), .pilot_sense(sense[2]), .upstream_main_valve_sense(sense[1]),
    .downstream_main_valve_sense(sense[0]), .ign_out(loads[3]), .pilot_out(loads[2]),
    .upstream_main_valve(loads[1]), .downstream_main_valve(loads[0]),
    .lockout(lockout), .hold_ind(hold_ind));

  bss_plant i_bss_plant (.clk(clk), .loads(loads), .sense(sense));

  // =============================================================
  // Bus and compare tasks
  // Request held until pready is seen high, then released
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic st(input logic [2:0] e);
    apb(1'b0, `BSS_STAT_OFS, 32'h0);
    chk("state", {29'h0, e}, {29'h0, rd[2:0]});
  endtask : st

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // Hang guard, about three times the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      tally_and_finish();
    end
  end

  // =============================================================
  // Test sequence
  initial begin
    wt(3);
    resetn <= 1'b1;
    wt(50); st(3'h0);
    wt(70); st(3'h1);
    $display("test initiate done");
    line_ok <= 1'b0;
    wt(20); st(3'h0);
    chk("hold", 32'h1, {31'h0, hold_ind});
    line_ok <= 1'b1;
    wt(20); chk("hold", 32'h1, {31'h0, hold_ind});
    wt(60); chk("hold", 32'h0, {31'h0, hold_ind});
    wt(40); st(3'h1);
    $display("test supply hold done");
    limit_ok <= 1'b1; pil <= 1'b1; demand <= 1'b1;
    wt(20); chk("loads", 32'hC, {28'h0, loads});
    flame <= 1'b1;
    wt(10); chk("loads", 32'h7, {28'h0, loads});
    st(3'h5);
    demand <= 1'b0; flame <= 1'b0;
    wt(10); chk("loads", 32'h0, {28'h0, loads});
    st(3'h1);
    $display("test run done");
    demand <= 1'b1;
    wt(140); chk("lockout", 32'h1, {31'h0, lockout});
    chk("loads", 32'h0, {28'h0, loads});
    apb(1'b0, `BSS_STAT_OFS, 32'h0);
    chk("fault", {24'h0, `BSS_FLT_NOFLAME}, {24'h0, rd[23:16]});
    demand <= 1'b0;
    wt(20); chk("lockout", 32'h1, {31'h0, lockout});
    apb(1'b1, `BSS_CTRL_OFS, 32'h1);
    wt(5); st(3'h0);
    $display("test trial lockout done");
    wt(120); ifault <= 1'b1;
    wt(5); chk("lockout", 32'h1, {31'h0, lockout});
    ifault <= 1'b0; rbtn <= 1'b1;
    wt(3); rbtn <= 1'b0;
    wt(3); chk("lockout", 32'h0, {31'h0, lockout});
    apb(1'b0, 12'h00C, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    $display("test fault and bus done");
    straps <= 3'h6; demand <= 1'b1;
    wt(120); flame <= 1'b1;
    wt(20); chk("loads", 32'hC, {28'h0, loads});
    wt(80); chk("loads", 32'h7, {28'h0, loads});
    wt(100); chk("loads", 32'h3, {28'h0, loads});
    flame <= 1'b0;
    wt(10); chk("loads", 32'hC, {28'h0, loads});
    st(3'h3);
    $display("test interrupted pilot done");
    tally_and_finish();
  end
endmodule : burner_safety_sequencer_test
